// ===== hdl/reset_seq_defs.svh
// Register offsets, field positions, reset values and delay figures for the reset sequencer.
// Assumes a 200 MHz system clock; included by the package and the reset_sequencer module.
// Summary of operation
// - Watchdog runs when software enable is 1, always when watchdog config is unprogrammed.
// - Watchdog time-out flag sets on time-out; clears on clear, power-save, power-on.
// - Sleep flag sets on power-save with operand 0; hardware clears it only on power-on.
// - Idle flag sets on power-save with operand 1; hardware clears it only on power-on.
// - Brown-out flag sets on brown-out and power-on resets; no hardware clear.
// - Power-on flag sets on every power-on reset; no hardware clear.
// - Trap, illegal-op, mismatch, pin and software flags set on events; power-on clears.
// - Software may set or clear any flag; setting never causes a reset.
// - Low-power config 1 keeps retention regulator off and ignores retention enable.
// - Retention active in sleep keeps SRAM contents intact.
// - Software brown-out enable matters only when brown-out config equals 01.
// - Wake from regulator standby waits extra delay unless the fast-wake bit is set.
// - Registers reset alike except status, oscillator, calibration and flash registers.
// - Power-on release after power-on, start-up, internal delays; brown-out skips power-on delay.
// - Pin, watchdog, software, illegal-op and trap resets hold only internal time.
// - Crystal start-up timer is a 10-bit counter of 1024 oscillator periods.
// - PLL sources add lock time before releasing the clock.
// - Oscillator and PLL delays run in parallel with the reset delay.
// - No code execution until a valid clock has been released.
// - Switching on: hard and pin resets use config select, other soft resets keep current select.
// - Two-speed start-up runs fast RC first, then switches to the primary.
// - Clock-fail monitor starts only after its delay following reset release.
// - Any active reset source asserts master system reset.
// - Power-on clears all flags except brown-out and power-on, which it sets.
`ifndef RESET_SEQ_DEFS_SVH
`define RESET_SEQ_DEFS_SVH
`define CLK_MHZ 200
`define OFS_CAUSE 12'h000
`define OFS_OSC 12'h004
`define OFS_CAL 12'h008
`define OFS_FLASH 12'h00C
`define OFS_STATUS 12'h010
`define BIT_TRAP 15
`define BIT_ILLOP 14
`define BIT_BOSW 13
`define BIT_RETAIN 12
`define BIT_CFGMM 9
`define BIT_FASTWK 8
`define BIT_PINRST 7
`define BIT_SWRST 6
`define BIT_WDSW 5
`define BIT_WDTMO 4
`define BIT_SLEEP 3
`define BIT_IDLE 2
`define BIT_BROWN 1
`define BIT_POR 0
`define CAUSE_WMASK 16'hF3FF
`define CAUSE_POR_VAL 16'h2003
`define POR_DELAY_US 10
`define RST_DELAY_US 2
`define POR_DELAY_CYC (`POR_DELAY_US * `CLK_MHZ)
`define RST_DELAY_CYC (`RST_DELAY_US * `CLK_MHZ)
`define STARTUP_CYC 100
`define XTAL_TICKS 1024
`define LOCK_CYC 200
`define FASTRC_CYC 20
`define SLOWRC_CYC 40
`define MON_CYC 50
`define VREG_CYC 60
`endif

// ===== hdl/reset_seq_pkg.sv
// Types shared by the reset sequencer modules.
// Assumes the constant header is on the include path.
`include "reset_seq_defs.svh"
package reset_seq_pkg;
   typedef enum logic [4:0] {
      ST_HOLD = 5'b00001,
      ST_PORD = 5'b00010,
      ST_STUP = 5'b00100,
      ST_IRST = 5'b01000,
      ST_RUN = 5'b10000
   } seq_state_t;
   typedef logic [2:0] osc_sel_t;
endpackage

// ===== hdl/delay_timer.sv
// Loadable down-counter that pulses done when a started count expires.
// Assumes start is a one-cycle pulse on the system clock.
`timescale 1ns/1ps
`default_nettype none
module delay_timer #(
   parameter int WIDTH = 16
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic start,
   input wire logic [WIDTH-1:0] count,
   output logic busy,
   output logic done
);
   logic [WIDTH-1:0] cnt_r;
   // Count down to one, then flag done for one cycle
   always_ff @(posedge clk) begin
      if (reset) begin
         cnt_r <= '0;
         done <= 1'b0;
      end else if (start) begin
         cnt_r <= (count == '0) ? {{(WIDTH-1){1'b0}}, 1'b1} : count;
         done <= 1'b0;
      end else begin
         done <= (cnt_r == {{(WIDTH-1){1'b0}}, 1'b1});
         if (cnt_r != '0) begin
            cnt_r <= cnt_r - {{(WIDTH-1){1'b0}}, 1'b1};
         end
      end
   end
   assign busy = (cnt_r != '0);
endmodule
`default_nettype wire

// ===== hdl/osc_startup.sv
// Oscillator release: start-up timer on oscillator ticks, then PLL lock count.
// Assumes osc_tick is already synchronised; one pulse per oscillator period.
`timescale 1ns/1ps
`default_nettype none
module osc_startup #(
   parameter int TMR_W = 10,
   parameter int LOCK_W = 16
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic start,
   input wire logic use_xtal,
   input wire logic use_pll,
   input wire logic [LOCK_W-1:0] lock_cycles,
   input wire logic [LOCK_W-1:0] rc_cycles,
   input wire logic osc_tick,
   output logic released
);
   logic [TMR_W-1:0] xtal_r;
   logic xtal_run_r;
   logic [LOCK_W-1:0] wait_r;
   logic phase2_r;
   // Start-up timer counts all 2^TMR_W periods and wraps to zero
   always_ff @(posedge clk) begin
      if (reset || start) begin
         xtal_r <= '0;
         xtal_run_r <= start && use_xtal;
      end else if (xtal_run_r && osc_tick) begin
         xtal_r <= xtal_r + {{(TMR_W-1){1'b0}}, 1'b1};
         if (xtal_r == {TMR_W{1'b1}}) begin
            xtal_run_r <= 1'b0;
         end
      end
   end
   // After the timer, wait lock time or RC start-up, then release
   always_ff @(posedge clk) begin
      if (reset) begin
         wait_r <= '0;
         phase2_r <= 1'b0;
         released <= 1'b0;
      end else if (start) begin
         wait_r <= use_pll ? lock_cycles : (use_xtal ? '0 : rc_cycles);
         phase2_r <= 1'b1;
         released <= 1'b0;
      end else if (phase2_r && !xtal_run_r) begin
         if (wait_r == '0) begin
            phase2_r <= 1'b0;
            released <= 1'b1;
         end else begin
            wait_r <= wait_r - {{(LOCK_W-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule
`default_nettype wire

// ===== hdl/reset_sequencer.sv
// Reset cause capture, master reset release timing and clock source selection.
// Assumes event inputs are one-cycle pulses from same-clock logic; pins and the
// brown-out/master-clear levels come asynchronously and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "reset_seq_defs.svh"
module reset_sequencer #(
   parameter int POR_CYC = `POR_DELAY_CYC,
   parameter int RST_CYC = `RST_DELAY_CYC,
   parameter int STARTUP = `STARTUP_CYC,
   parameter int LOCK = `LOCK_CYC,
   parameter int FASTRC = `FASTRC_CYC,
   parameter int SLOWRC = `SLOWRC_CYC,
   parameter int MON_DLY = `MON_CYC,
   parameter int VREG = `VREG_CYC
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic brownout_level,
   input wire logic master_clear_pin_n,
   input wire logic osc_tick,
   input wire logic watchdog_timeout,
   input wire logic sw_reset_instr,
   input wire logic trap_conflict,
   input wire logic illegal_op,
   input wire logic config_mismatch,
   input wire logic watchdog_clear_instr,
   input wire logic power_save_instr,
   input wire logic power_save_operand,
   input wire logic wake_event,
   input wire logic regulator_standby,
   input wire logic [1:0] watchdog_cfg,
   input wire logic [1:0] brownout_cfg,
   input wire logic low_power_cfg,
   input wire logic clock_switch_en,
   input wire logic two_speed_en,
   input wire reset_seq_pkg::osc_sel_t initial_osc_select,
   input wire reset_seq_pkg::osc_sel_t new_osc_select,
   input wire logic osc_switch_req,
   output logic master_system_reset,
   output logic cpu_run,
   output logic clock_released,
   output logic watchdog_enable,
   output logic brownout_detect_en,
   output logic retention_active,
   output logic sram_hold,
   output logic wake_done,
   output logic clock_fail_monitor_en,
   output reset_seq_pkg::osc_sel_t current_osc_select,
   output logic on_fast_rc
);
   import reset_seq_pkg::*;

   localparam osc_sel_t OSC_FASTRC = 3'h0;
   localparam osc_sel_t OSC_FASTPLL = 3'h1;
   localparam osc_sel_t OSC_XT = 3'h2;
   localparam osc_sel_t OSC_XTPLL = 3'h3;
   localparam osc_sel_t OSC_ECPLL = 3'h5;
   localparam osc_sel_t OSC_SLOWRC = 3'h6;
   localparam osc_sel_t OSC_FASTDIV = 3'h7;

   // Source is a crystal that needs the start-up timer
   function automatic logic is_crystal(input osc_sel_t s);
      is_crystal = (s == OSC_XT) || (s == OSC_XTPLL);
   endfunction
   function automatic logic is_pll(input osc_sel_t s);
      is_pll = (s == OSC_XTPLL) || (s == OSC_ECPLL) || (s == OSC_FASTPLL);
   endfunction
   function automatic logic is_rc(input osc_sel_t s);
      is_rc = (s == OSC_FASTRC) || (s == OSC_FASTPLL) || (s == OSC_SLOWRC) || (s == OSC_FASTDIV);
   endfunction

   // Two-flop synchronisers for asynchronous levels
   logic [1:0] bo_sync_r, pin_sync_r, tick_sync_r;
   logic bo_q_r, pin_q_r, tick_q_r;
   always_ff @(posedge clk) begin
      bo_sync_r <= {bo_sync_r[0], brownout_level};
      pin_sync_r <= {pin_sync_r[0], master_clear_pin_n};
      tick_sync_r <= {tick_sync_r[0], osc_tick};
      bo_q_r <= bo_sync_r[1];
      pin_q_r <= pin_sync_r[1];
      tick_q_r <= tick_sync_r[1];
   end
   logic bo_rise, pin_fall, tick_pulse;
   assign bo_rise = bo_sync_r[1] & ~bo_q_r & brownout_detect_en;
   assign pin_fall = ~pin_sync_r[1] & pin_q_r;
   assign tick_pulse = tick_sync_r[1] & ~tick_q_r;

   // Soft resets that only hold the internal reset time
   logic soft_rst, hard_rst, any_rst, apb_wr, apb_rd;
   assign soft_rst = pin_fall | watchdog_timeout | sw_reset_instr | trap_conflict | illegal_op
      | config_mismatch;
   assign hard_rst = bo_rise;
   assign any_rst = soft_rst | hard_rst;
   assign apb_wr = psel & penable & pwrite;
   assign apb_rd = psel & ~penable & ~pwrite;

   // Cause register; hardware set beats software clear
   logic [15:0] cause_r, cause_set, cause_clr, wmask;
   always_comb begin
      cause_set = 16'h0000;
      cause_clr = 16'h0000;
      cause_set[`BIT_TRAP] = trap_conflict;
      cause_set[`BIT_ILLOP] = illegal_op;
      cause_set[`BIT_CFGMM] = config_mismatch;
      cause_set[`BIT_PINRST] = pin_fall;
      cause_set[`BIT_SWRST] = sw_reset_instr;
      cause_set[`BIT_WDTMO] = watchdog_timeout;
      cause_set[`BIT_SLEEP] = power_save_instr & ~power_save_operand;
      cause_set[`BIT_IDLE] = power_save_instr & power_save_operand;
      cause_set[`BIT_BROWN] = bo_rise;
      cause_clr[`BIT_WDTMO] = watchdog_clear_instr | power_save_instr;
   end
   assign wmask = (apb_wr && paddr == `OFS_CAUSE) ? `CAUSE_WMASK : 16'h0000;
   always_ff @(posedge clk) begin
      if (reset) begin
         cause_r <= `CAUSE_POR_VAL;
      end else begin
         // Software writes touch flag and control bits only; no reset path from here
         cause_r <= (((cause_r & ~wmask) | (pwdata[15:0] & wmask)) & ~cause_clr) | cause_set;
      end
   end

   // Registers cleared only by power-on reset
   logic [15:0] cal_r, flash_r;
   always_ff @(posedge clk) begin
      if (reset) begin
         cal_r <= 16'h0000;
         flash_r <= 16'h0000;
      end else if (apb_wr && paddr == `OFS_CAL) begin
         cal_r <= pwdata[15:0];
      end else if (apb_wr && paddr == `OFS_FLASH) begin
         flash_r <= pwdata[15:0];
      end
   end

   // Policy outputs from configuration and control bits
   assign watchdog_enable = (watchdog_cfg == 2'b11) | cause_r[`BIT_WDSW];
   assign brownout_detect_en = (brownout_cfg == 2'b01) ? cause_r[`BIT_BOSW] : brownout_cfg[1];
   logic sleeping_r;
   assign retention_active = sleeping_r & ~low_power_cfg & cause_r[`BIT_RETAIN];
   assign sram_hold = retention_active;

   // Reset sequence state machine
   seq_state_t state_r;
   logic was_por_r, t_start, t_done, t_busy, osc_start, osc_rel;
   logic [15:0] t_count;
   always_ff @(posedge clk) begin
      if (reset) begin
         state_r <= ST_HOLD;
         was_por_r <= 1'b1;
      end else if (any_rst) begin
         state_r <= hard_rst ? ST_STUP : ST_IRST;
         was_por_r <= 1'b0;
      end else begin
         case (state_r)
            ST_HOLD: begin
               state_r <= ST_PORD;
            end
            ST_PORD: begin
               if (t_done) begin
                  state_r <= ST_STUP;
               end
            end
            ST_STUP: begin
               if (t_done) begin
                  state_r <= ST_IRST;
               end
            end
            ST_IRST: begin
               if (t_done) begin
                  state_r <= ST_RUN;
               end
            end
            default: begin
               state_r <= ST_RUN;
            end
         endcase
      end
   end
   assign t_start = (state_r == ST_HOLD) | any_rst | (t_done & (state_r != ST_IRST));
   always_comb begin
      if (state_r == ST_HOLD) begin
         t_count = POR_CYC[15:0];
      end else if (any_rst) begin
         t_count = hard_rst ? STARTUP[15:0] : RST_CYC[15:0];
      end else if (state_r == ST_PORD) begin
         t_count = STARTUP[15:0];
      end else begin
         t_count = RST_CYC[15:0];
      end
   end
   delay_timer #(.WIDTH(16)) seq_timer (
      .clk(clk),
      .reset(reset),
      .start(t_start),
      .count(t_count),
      .busy(t_busy),
      .done(t_done)
   );
   assign master_system_reset = (state_r != ST_RUN);

   // Clock source chosen at reset
   osc_sel_t osc_r, target_osc;
   assign target_osc = (!clock_switch_en || hard_rst || pin_fall || state_r == ST_HOLD) ?
      initial_osc_select : osc_r;
   always_ff @(posedge clk) begin
      if (reset) begin
         osc_r <= 3'h0;
      end else if (state_r == ST_HOLD || any_rst) begin
         osc_r <= target_osc;
      end else if (osc_switch_req && clock_switch_en && !master_system_reset) begin
         osc_r <= new_osc_select;
      end
   end
   assign current_osc_select = osc_r;

   // Oscillator release runs alongside the reset delay
   logic two_speed_r;
   assign osc_start = (state_r == ST_HOLD) | hard_rst;
   osc_startup #(.TMR_W(10), .LOCK_W(16)) osc_seq (
      .clk(clk),
      .reset(reset),
      .start(osc_start),
      .use_xtal(is_crystal(target_osc)),
      .use_pll(is_pll(target_osc)),
      .lock_cycles(LOCK[15:0]),
      .rc_cycles((target_osc == OSC_SLOWRC) ? SLOWRC[15:0] : FASTRC[15:0]),
      .osc_tick(tick_pulse),
      .released(osc_rel)
   );
   // Two-speed start: run on fast RC until primary is released
   always_ff @(posedge clk) begin
      if (reset) begin
         two_speed_r <= 1'b0;
      end else if (osc_start) begin
         two_speed_r <= two_speed_en && !is_rc(target_osc);
      end else if (osc_rel) begin
         two_speed_r <= 1'b0;
      end
   end
   assign on_fast_rc = two_speed_r;
   assign clock_released = osc_rel | two_speed_r | (!is_crystal(osc_r) && !is_pll(osc_r) && !osc_start
      && state_r != ST_HOLD && was_por_r == 1'b0);
   assign cpu_run = ~master_system_reset & clock_released & ~sleeping_r;

   // Clock-fail monitor delay after reset release
   logic [15:0] mon_r;
   always_ff @(posedge clk) begin
      if (reset || master_system_reset) begin
         mon_r <= MON_DLY[15:0];
         clock_fail_monitor_en <= 1'b0;
      end else if (mon_r != 16'h0000) begin
         mon_r <= mon_r - 16'h0001;
      end else begin
         clock_fail_monitor_en <= 1'b1;
      end
   end

   // Sleep and wake with optional regulator delay
   logic [15:0] wake_r;
   logic standby_r;
   always_ff @(posedge clk) begin
      if (reset) begin
         sleeping_r <= 1'b0;
         standby_r <= 1'b0;
         wake_r <= 16'h0000;
         wake_done <= 1'b0;
      end else begin
         wake_done <= 1'b0;
         if (power_save_instr && !power_save_operand) begin
            sleeping_r <= 1'b1;
            standby_r <= 1'b0;
         end else if (sleeping_r && regulator_standby) begin
            standby_r <= 1'b1;
         end
         if (sleeping_r && wake_event && wake_r == 16'h0000) begin
            if (standby_r && !cause_r[`BIT_FASTWK]) begin
               wake_r <= VREG[15:0];
            end else begin
               sleeping_r <= 1'b0;
               wake_done <= 1'b1;
            end
         end else if (wake_r != 16'h0000) begin
            wake_r <= wake_r - 16'h0001;
            if (wake_r == 16'h0001) begin
               sleeping_r <= 1'b0;
               wake_done <= 1'b1;
            end
         end
      end
   end

   // APB read data, registered in the setup cycle
   always_ff @(posedge clk) begin
      if (reset) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (apb_rd || (psel && !penable)) begin
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         if (paddr == `OFS_CAUSE) begin
            prdata <= {16'h0000, cause_r};
         end else if (paddr == `OFS_OSC) begin
            prdata <= {17'h0_0000, osc_r, 12'h000};
         end else if (paddr == `OFS_CAL) begin
            prdata <= {16'h0000, cal_r};
         end else if (paddr == `OFS_FLASH) begin
            prdata <= {16'h0000, flash_r};
         end else if (paddr == `OFS_STATUS) begin
            prdata <= {25'h000_0000, t_busy, clock_fail_monitor_en, on_fast_rc, sleeping_r,
               clock_released, cpu_run, master_system_reset};
         end else begin
            pslverr <= 1'b1;
         end
      end
   end
   assign pready = 1'b1;
endmodule
`default_nettype wire

// ===== tb/reset_seq_checker.sv
// Port assertions for the reset sequencer.
// Bound from the bench top; single clock, sync reset.
`timescale 1ns/1ps
`default_nettype none
module reset_seq_checker #(
   parameter int POR_CYC = 10,
   parameter int RST_CYC = 8,
   parameter int STARTUP = 6
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic watchdog_timeout,
   input wire logic sw_reset_instr,
   input wire logic trap_conflict,
   input wire logic illegal_op,
   input wire logic config_mismatch,
   input wire logic [1:0] watchdog_cfg,
   input wire logic [1:0] brownout_cfg,
   input wire logic low_power_cfg,
   input wire logic master_system_reset,
   input wire logic cpu_run,
   input wire logic clock_released,
   input wire logic watchdog_enable,
   input wire logic brownout_detect_en,
   input wire logic retention_active,
   input wire logic clock_fail_monitor_en
);
   localparam int POR_A = POR_CYC + STARTUP + RST_CYC - 8;
   localparam int POR_B = POR_A + 16;
   localparam int RST_B = RST_CYC + 4;
   logic evt;
   // Any same-clock reset event
   assign evt = watchdog_timeout | sw_reset_instr | trap_conflict | illegal_op | config_mismatch;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   AST_WDT_CFG: assert property (watchdog_cfg == 2'b11 |-> watchdog_enable)
      else $error("watchdog off with config unprogrammed");
   AST_BO_IGNORE: assert property (brownout_cfg != 2'b01 |-> brownout_detect_en == brownout_cfg[1])
      else $error("brown-out enable follows software bit");
   AST_RET_OFF: assert property (low_power_cfg |-> !retention_active)
      else $error("retention active with low-power config set");
   AST_RUN_CLOCK: assert property (cpu_run |-> clock_released && !master_system_reset)
      else $error("execution without released clock");
   AST_EVT_RESET: assert property (evt |-> ##[1:3] master_system_reset)
      else $error("reset event did not assert master reset");
   AST_SOFT_SHORT: assert property (sw_reset_instr && !master_system_reset |->
      ##[1:3] master_system_reset ##1 master_system_reset [*7] ##[1:RST_B] !master_system_reset)
      else $error("software reset hold time wrong");
   AST_POR_TIME: assert property ($fell(reset) |-> master_system_reset [*8] ##[POR_A:POR_B] !master_system_reset)
      else $error("power-on release time wrong");
   AST_MON_WAIT: assert property ($fell(master_system_reset) |-> !clock_fail_monitor_en [*4])
      else $error("clock monitor enabled too early");
   AST_SW_NO_RST: assert property (psel && penable && pwrite && !master_system_reset && !evt |=> !master_system_reset)
      else $error("register write caused a reset");
   AST_READY: assert property (psel && penable && paddr inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h010} |->
      pready && !pslverr)
      else $error("mapped access not completed cleanly");
   // Main scenarios reached
   cover property (sw_reset_instr ##[1:3] master_system_reset);
   cover property ($rose(cpu_run));
   cover property (psel && penable && pslverr);
endmodule
`default_nettype wire

// ===== tb/reset_cause_and_release_sequencer_test.sv
// Self-checking bench for the reset sequencer.
// Drives every port directly; APB master with short delay parameters.
`timescale 1ns/1ps
`default_nettype none
module reset_cause_and_release_sequencer_test;
   import reset_seq_pkg::*;
   logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, osc_tick = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic pready, pslverr, msr, cpu_run, clk_rel, wdt_en, bo_en, ret_act, mon_en, err, wd;
   logic bo_lvl = 0, pin_n = 1, wclr = 0, ps = 0, ps_op = 0, wake = 0, lpc = 1;
   logic stby = 0, csw = 1, tse = 0, oreq = 0;
   osc_sel_t isel = 3'h0, nsel = 3'h0, cur_osc;
   localparam int PC = 10, RC = 8, SC = 6, QC = 5;
   logic [4:0] evt = 0;
   logic [1:0] wcfg = 0, bcfg = 2'b01;
   int err_count = 0, check_count = 0, cycles = 0;
   int ebit [5] = '{4, 6, 15, 14, 9};
   // Clock and oscillator ticks
   always #2.5 clk = ~clk;
   always @(posedge clk) osc_tick <= ~osc_tick;
   reset_sequencer #(.POR_CYC(PC), .RST_CYC(RC), .STARTUP(SC), .LOCK(QC), .FASTRC(QC), .SLOWRC(QC),
      .MON_DLY(QC), .VREG(QC))
   i_reset_sequencer (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .brownout_level(bo_lvl), .master_clear_pin_n(pin_n), .osc_tick(osc_tick),
      .watchdog_timeout(evt[0]), .sw_reset_instr(evt[1]), .trap_conflict(evt[2]), .illegal_op(evt[3]),
      .config_mismatch(evt[4]), .watchdog_clear_instr(wclr), .power_save_instr(ps), .power_save_operand(ps_op),
      .wake_event(wake), .regulator_standby(stby), .watchdog_cfg(wcfg), .brownout_cfg(bcfg),
      .low_power_cfg(lpc), .clock_switch_en(csw), .two_speed_en(tse), .initial_osc_select(isel),
      .new_osc_select(nsel), .osc_switch_req(oreq), .master_system_reset(msr), .cpu_run(cpu_run),
      .clock_released(clk_rel), .watchdog_enable(wdt_en), .brownout_detect_en(bo_en),
      .retention_active(ret_act), .sram_hold(), .wake_done(wd), .clock_fail_monitor_en(mon_en),
      .current_osc_select(cur_osc), .on_fast_rc());
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One APB transfer; read data and error taken at the ready edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic wait_hi();
      int n;
      n = 0;
      while (msr !== 1'b1 && n < 8) begin
         @(posedge clk);
         n++;
      end
      chk("master reset", 1, msr);
   endtask
   task automatic wait_run();
      int n;
      n = 0;
      while (cpu_run !== 1'b1 && n < 300) begin
         @(posedge clk);
         n++;
      end
      chk("cpu run", 1, cpu_run);
   endtask
   task automatic t_por();
      wait_run();
      apb(0, 12'h000, 0);
      chk("cause at power-on", 32'h0000_2003, rd);
      apb(0, 12'h014, 0);
      chk("unmapped error", 1, err);
      $display("power-on test done");
   endtask
   task automatic t_regs();
      apb(1, 12'h000, 32'h0000_FFFF);
      apb(0, 12'h000, 0);
      chk("cause all set", 32'h0000_F3FF, rd);
      chk("no reset on write", 0, msr);
      chk("wdt sw on", 1, wdt_en);
      chk("brown-out sw on", 1, bo_en);
      apb(1, 12'h000, 0);
      @(posedge clk);
      chk("wdt sw off", 0, wdt_en);
      chk("brown-out sw off", 0, bo_en);
      wcfg <= 2'b11;
      bcfg <= 2'b00;
      lpc <= 0;
      apb(1, 12'h000, 32'h0000_3000);
      @(posedge clk);
      chk("wdt forced", 1, wdt_en);
      chk("brown-out ignored", 0, bo_en);
      wcfg <= 2'b00;
      bcfg <= 2'b01;
      lpc <= 1;
      $display("register test done");
   endtask
   task automatic t_events();
      isel <= 3'h7;
      for (int i = 0; i < 5; i++) begin
         apb(1, 12'h000, 0);
         evt <= 5'h01 << i;
         @(posedge clk);
         evt <= 0;
         wait_hi();
         wait_run();
         apb(0, 12'h000, 0);
         chk("event flag", 32'h1 << ebit[i], rd);
         chk("osc kept", 0, cur_osc);
      end
      $display("event test done");
   endtask
   task automatic t_power();
      apb(1, 12'h000, 32'h0000_0010);
      wclr <= 1;
      @(posedge clk);
      wclr <= 0;
      apb(0, 12'h000, 0);
      chk("clear wdt flag", 0, rd);
      apb(1, 12'h000, 32'h0000_0010);
      for (int op = 0; op < 2; op++) begin
         ps <= 1;
         ps_op <= op[0];
         @(posedge clk);
         ps <= 0;
         apb(0, 12'h000, 0);
         chk("power-save flags", op ? 32'h0000_000C : 32'h0000_0008, rd);
         wake <= 1;
         @(posedge clk);
         wake <= 0;
         @(posedge clk);
         chk("wake pulse", !op, wd);
         wait_run();
      end
      $display("power-save test done");
   endtask
   task automatic t_pins();
      apb(1, 12'h000, 32'h0000_2000);
      pin_n <= 0;
      wait_hi();
      pin_n <= 1;
      wait_run();
      apb(0, 12'h000, 0);
      chk("pin flag", 1, rd[7]);
      chk("osc from config", 7, cur_osc);
      apb(1, 12'h000, 32'h0000_2000);
      bo_lvl <= 1;
      wait_hi();
      bo_lvl <= 0;
      wait_run();
      apb(0, 12'h000, 0);
      chk("brown-out flag", 1, rd[1]);
      apb(1, 12'h000, 32'h0000_FFFF);
      reset <= 1;
      repeat (4) @(posedge clk);
      reset <= 0;
      wait_run();
      apb(0, 12'h000, 0);
      chk("cause after second power-on", 32'h0000_2003, rd);
      $display("pin and brown-out test done");
   endtask
   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         close_out();
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      reset <= 0;
      t_por();
      t_regs();
      t_events();
      t_power();
      t_pins();
      close_out();
   end
endmodule
bind reset_sequencer reset_seq_checker #(.POR_CYC(POR_CYC), .RST_CYC(RST_CYC), .STARTUP(STARTUP))
i_reset_seq_checker (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pready(pready), .pslverr(pslverr), .watchdog_timeout(watchdog_timeout),
   .sw_reset_instr(sw_reset_instr), .trap_conflict(trap_conflict), .illegal_op(illegal_op),
   .config_mismatch(config_mismatch), .watchdog_cfg(watchdog_cfg), .brownout_cfg(brownout_cfg),
   .low_power_cfg(low_power_cfg), .master_system_reset(master_system_reset), .cpu_run(cpu_run),
   .clock_released(clock_released), .watchdog_enable(watchdog_enable),
   .brownout_detect_en(brownout_detect_en), .retention_active(retention_active),
   .clock_fail_monitor_en(clock_fail_monitor_en));
`default_nettype wire
